// ---- framer_alarm_event_interrupts.sv ----
`timescale 1ns/1ps
// Functional notes
// - line condition mask bits interrupt on both edges
// - timer, signaling, jitter mask bits gate events
// - clear events set when conditions stop
// - sync achieved event held until read
// - yellow (T1) and all-ones condition bits
// - carrier loss after 192/255/2048 zeros
// - loss-of-sync bit held while unsynchronized
// - second mask: events gated, conditions rising-edge only
// - T1 spare, loop-down, loop-up double-interrupt conditions
// - transmit clock loss, optional clock-loss pin
// - receive clock loss after one channel time
// - E1 V5.2 link and remote alarm conditions
// - distant multiframe alarm after two multiframes
// - third mask bits interrupt on both edges
// - T1 customer AIS pattern event
// - E1 signaling all-ones event
// - E1 signaling all-zeros event
// - transmit multiframe event every boundary
// - receive multiframe event every boundary
// - E1 transmit and receive align-frame events
// - CRC4 multiframe event, 2ms tick when disabled
// - all status and mask bits reset to zero
// - summary bit per register with enabled interrupt
module framer_alarm_event_interrupts #(
    parameter int unsigned MF_TICK_CYCLES = framer_alarm_pkg::MF_TICK_CYC
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire framer_alarm_pkg::detect_t det,
    input  wire framer_alarm_pkg::event_t  evt,
    input  wire logic                      rx_bit_strobe,
    input  wire logic                      receive_positive_input,
    input  wire logic                      receive_negative_input,
    input  wire logic                      ts16_frame0_bit6,
    input  wire logic                      transmit_clock_pin,
    input  wire logic                      receive_data_clock_input,
    output logic                           clock_loss_pin,
    output logic                           irq
);
    import framer_alarm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    cfg_t                       cfg;
    logic [3:0][7:0]            mask;
    logic [3:0][7:0]            status;
    logic [3:0][7:0]            pending;
    logic [3:0][7:0]            src;
    logic [3:0][7:0]            src_prev;
    logic [3:0]                 rd_clr;
    logic [3:0]                 summary;

    function automatic logic idx_is(input logic [7:0] addr, input logic [7:0] idx);
        return addr[7:2] == idx[5:0] && addr[1:0] == 2'h0 && idx[7:6] == 2'h0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // framer carrier loss: run of zeros on both rails
    logic [ZERO_W-1:0]          zero_run;
    logic                       framer_carrier_loss;
    wire  logic [ZERO_W-1:0]    zero_limit = !cfg.e1_mode ? T1_ZERO_RUN :
                                             cfg.extended_carrier_loss_select ? E1_ZERO_RUN_EXT : E1_ZERO_RUN;
    wire  logic                 rx_one     = receive_positive_input | receive_negative_input;
    wire  logic                 run_full   = zero_run >= zero_limit;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            zero_run <= '0;
        end else if (rx_bit_strobe) begin
            zero_run <= rx_one ? '0 : (run_full ? zero_run : zero_run + 1'b1);
        end
    end
    // a mode change re-evaluates at once, no need to wait for a new run
    assign framer_carrier_loss = run_full;

    ////////////////////////////////////////////////////////////////////////////
    // clock activity monitors, one channel time of silence
    logic [IDLE_W-1:0]          tx_idle;
    logic [IDLE_W-1:0]          rx_idle;
    logic                       tx_clk_prev;
    logic                       rx_clk_prev;
    wire  logic [IDLE_W-1:0]    chan_cyc = cfg.e1_mode ? IDLE_W'(E1_CHANNEL_CYC) : IDLE_W'(T1_CHANNEL_CYC);
    wire  logic                 transmit_clock_loss = tx_idle >= chan_cyc;
    wire  logic                 receive_clock_loss  = rx_idle >= chan_cyc;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_prev <= 1'b0;
            rx_clk_prev <= 1'b0;
            tx_idle     <= '0;
            rx_idle     <= '0;
        end else begin
            tx_clk_prev <= transmit_clock_pin;
            rx_clk_prev <= receive_data_clock_input;
            tx_idle     <= (transmit_clock_pin != tx_clk_prev) ? '0 :
                           (transmit_clock_loss ? tx_idle : tx_idle + 1'b1);
            rx_idle     <= (receive_data_clock_input != rx_clk_prev) ? '0 :
                           (receive_clock_loss ? rx_idle : rx_idle + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_loss_pin <= 1'b0;
        end else begin
            clock_loss_pin <= transmit_clock_loss & cfg.clock_loss_pin_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // distant multiframe alarm and free-running 2ms tick
    logic [1:0]                 dma_run;
    logic [$clog2(MF_TICK_CYCLES)-1:0] mf_cnt;
    wire  logic                 mf_tick = mf_cnt == ($clog2(MF_TICK_CYCLES))'(MF_TICK_CYCLES - 1);
    wire  logic                 distant_multiframe_alarm = dma_run[1] & cfg.e1_mode;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_run <= 2'h0;
            mf_cnt  <= '0;
        end else begin
            mf_cnt <= mf_tick ? '0 : mf_cnt + 1'b1;
            // sampled regardless of signaling mode
            if (evt.receive_multiframe_event) begin
                dma_run <= ts16_frame0_bit6 ? {dma_run[0], 1'b1} : 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status sources per group
    wire  logic t1 = !cfg.e1_mode;
    wire  logic e1 = cfg.e1_mode;
    wire  logic yellow_alarm_condition      = det.yellow_alarm_condition & t1;
    wire  logic unframed_all_ones_condition = det.unframed_all_ones_condition;
    wire  logic loss_of_sync_condition      = det.loss_of_sync_condition;
    wire  logic yellow_alarm_clear_event    = src_prev[1][3] & ~yellow_alarm_condition;
    wire  logic all_ones_clear_event        = src_prev[1][2] & ~unframed_all_ones_condition;
    wire  logic framer_carrier_loss_clear   = src_prev[1][1] & ~framer_carrier_loss;
    wire  logic sync_achieved_event         = src_prev[1][0] & ~loss_of_sync_condition;
    wire  logic crc4_mf = cfg.crc4_enable ? evt.receive_crc4_multiframe_event : mf_tick;

    assign src[0] = {det.input_level_low, evt.timer_event, evt.signaling_change_event,
                     evt.jitter_limit_trip_event, det.line_carrier_loss, det.current_limit_exceeded,
                     det.output_open_circuit, det.line_transmit_clock_loss};
    assign src[1] = {yellow_alarm_clear_event, all_ones_clear_event, framer_carrier_loss_clear,
                     sync_achieved_event, yellow_alarm_condition, unframed_all_ones_condition,
                     framer_carrier_loss, loss_of_sync_condition};
    assign src[2] = {det.spare_code_detected & t1, det.loop_down_detected & t1,
                     det.loop_up_detected & t1, transmit_clock_loss, receive_clock_loss,
                     det.v52_link_detected & e1, distant_multiframe_alarm,
                     det.remote_alarm_condition & e1};
    assign src[3] = {evt.ais_customer_pattern_event & t1, evt.signaling_all_ones_event & e1,
                     evt.signaling_all_zeros_event & e1, evt.transmit_multiframe_event,
                     evt.transmit_align_frame_event & e1, evt.receive_multiframe_event,
                     crc4_mf & e1, evt.receive_align_frame_event & e1};

    ////////////////////////////////////////////////////////////////////////////
    // latching: event pulses and condition levels both stay set until read,
    // interrupt pending set by event, rising edge or either edge
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
        wire logic [7:0] rise = src[g] & ~src_prev[g];
        wire logic [7:0] fall = ~src[g] & src_prev[g];
        wire logic [7:0] hit  = (EVENT_BITS[g] & src[g]) |
                                (~EVENT_BITS[g] & rise) |
                                (BOTH_BITS[g] & fall);

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                status[g]   <= RESET_BYTE;
                pending[g]  <= RESET_BYTE;
                src_prev[g] <= RESET_BYTE;
            end else begin
                src_prev[g] <= src[g];
                // set wins over the read-clear in the same cycle
                status[g]   <= (status[g] & ~{8{rd_clr[g]}}) | src[g];
                pending[g]  <= (pending[g] & ~{8{rd_clr[g]}}) | hit;
            end
        end
        assign summary[g] = |(pending[g] & mask[g]);
    end

    assign irq = |summary;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    logic                       aw_held;
    logic                       w_held;
    logic [7:0]                 aw_addr;
    logic [7:0]                 w_byte;
    logic                       w_lane;
    wire  logic                 do_write = aw_held & w_held & ~s_axi_bvalid;
    wire  logic                 wr_cfg   = idx_is(aw_addr, IDX_CONFIG);
    wire  logic [3:0]           wr_mask  = {idx_is(aw_addr, IDX_FRAME_MK), idx_is(aw_addr, IDX_LOOP_CLK_MK),
                                            idx_is(aw_addr, IDX_RX_ALARM_MK), idx_is(aw_addr, IDX_LINE_MASK)};
    wire  logic [3:0]           wr_stat  = {idx_is(aw_addr, STATUS_IDX[3]), idx_is(aw_addr, STATUS_IDX[2]),
                                            idx_is(aw_addr, STATUS_IDX[1]), idx_is(aw_addr, STATUS_IDX[0])};
    wire  logic                 wr_known = wr_cfg | (|wr_mask) | (|wr_stat) | idx_is(aw_addr, IDX_SUMMARY);

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_byte       <= 8'h00;
            w_lane       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // status and summary are read-only; writes there are accepted and dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg  <= CFG_RESET;
            mask <= {NUM_GROUPS{RESET_BYTE}};
        end else if (do_write && w_lane) begin
            if (wr_cfg) begin
                cfg <= cfg_t'(w_byte[3:0]);
            end
            for (int i = 0; i < NUM_GROUPS; i++) begin
                if (wr_mask[i]) begin
                    mask[i] <= w_byte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path; reading a status register clears it
    logic [7:0]                 rd_byte;
    logic                       rd_known;
    wire  logic                 rd_take  = s_axi_arvalid & s_axi_arready;

    always_comb begin
        rd_byte  = 8'h00;
        rd_known = 1'b1;
        rd_clr   = 4'h0;
        if (idx_is(s_axi_araddr, IDX_SUMMARY)) begin
            rd_byte = {4'h0, summary};
        end else if (idx_is(s_axi_araddr, IDX_CONFIG)) begin
            rd_byte = {4'h0, cfg};
        end else begin
            rd_known = 1'b0;
            for (int i = 0; i < NUM_GROUPS; i++) begin
                if (idx_is(s_axi_araddr, STATUS_IDX[i])) begin
                    rd_byte   = status[i];
                    rd_known  = 1'b1;
                    rd_clr[i] = rd_take;
                end else if (idx_is(s_axi_araddr, STATUS_IDX[i] + 8'h01)) begin
                    rd_byte  = mask[i];
                    rd_known = 1'b1;
                end
            end
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_sync_gain;
        $fell(det.loss_of_sync_condition);
    endsequence
    sequence s_held_unread;
        status[1][4] && !rd_clr[1];
    endsequence
    a_rise_only_irq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(det.loss_of_sync_condition) && mask[1][0] |=> irq && pending[1][0])
        else $error("loss of sync rise with mask set gave no interrupt");
    a_sync_event_set: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_sync_gain |=> status[1][4])
        else $error("sync achieved event not latched");
    a_sync_event_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_held_unread |=> status[1][4])
        else $error("sync achieved event lost without a read");
    a_yellow_clear_evt: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg.e1_mode && $fell(det.yellow_alarm_condition) && !$changed(cfg) |=> status[1][7])
        else $error("yellow clear event not set");
    a_carrier_zero_run: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_bit_strobe && !rx_one && zero_run == zero_limit - 1'b1 && !$changed(cfg) |=> framer_carrier_loss)
        else $error("carrier loss not flagged at zero threshold");
    a_clock_loss_pin: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        transmit_clock_pin == tx_clk_prev && tx_idle == chan_cyc - 1'b1 && cfg.clock_loss_pin_enable
        && !$changed(cfg) |=> ##1 clock_loss_pin)
        else $error("clock loss pin not driven");
    a_rx_clock_loss: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(receive_data_clock_input) |=> !receive_clock_loss)
        else $error("receive clock loss despite a toggle");
    a_both_edge_irq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(det.v52_link_detected) && $past(cfg.e1_mode) && cfg.e1_mode && mask[2][2] |=> irq)
        else $error("falling edge of link condition gave no interrupt");
    a_line_fall_irq: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(det.line_carrier_loss) && mask[0][3] |=> pending[0][3])
        else $error("line carrier loss fall not pending");
    a_crc4_tick: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mf_tick && cfg.e1_mode && !cfg.crc4_enable |=> status[3][1])
        else $error("free-running multiframe tick not latched");
    // quiet sources and no mask write, so a frame status read must drop the line
    a_irq_release: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_clr[3] && !(|src) && !(|src_prev[2:0]) && !(|(pending[2:0] & mask[2:0])) && !do_write |=> !irq)
        else $error("interrupt held after all pending cleared");
endmodule // framer_alarm_event_interrupts

// ---- framer_alarm_pkg.sv ----
package framer_alarm_pkg;

    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned NUM_GROUPS      = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_SUMMARY     = 8'h14;
    localparam logic [7:0]  IDX_LINE_STATUS = 8'h16;
    localparam logic [7:0]  IDX_LINE_MASK   = 8'h17;
    localparam logic [7:0]  IDX_RX_ALARM_ST = 8'h18;
    localparam logic [7:0]  IDX_RX_ALARM_MK = 8'h19;
    localparam logic [7:0]  IDX_LOOP_CLK_ST = 8'h1A;
    localparam logic [7:0]  IDX_LOOP_CLK_MK = 8'h1B;
    localparam logic [7:0]  IDX_FRAME_ST    = 8'h1C;
    localparam logic [7:0]  IDX_FRAME_MK    = 8'h1D;
    localparam logic [7:0]  IDX_CONFIG      = 8'h30;

    // per group {3,2,1,0}: status index, event bits, both-edge bits (rest rise only)
    localparam logic [3:0][7:0] STATUS_IDX  = {8'h1C, 8'h1A, 8'h18, 8'h16};
    localparam logic [3:0][7:0] EVENT_BITS  = {8'hFF, 8'h00, 8'hF0, 8'h70};
    localparam logic [3:0][7:0] BOTH_BITS   = {8'h00, 8'hFF, 8'h00, 8'h8F};

    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [3:0]  CFG_RESET       = 4'h0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // timing
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned T1_CHANNEL_NS   = 5181;
    localparam int unsigned E1_CHANNEL_NS   = 3906;
    localparam int unsigned T1_CHANNEL_CYC  = (T1_CHANNEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned E1_CHANNEL_CYC  = (E1_CHANNEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IDLE_W          = 9;
    localparam int unsigned MF_TICK_US      = 2000;
    localparam int unsigned MF_TICK_CYC     = MF_TICK_US * 1000 / CLK_PERIOD_NS;

    // carrier loss zero-run thresholds
    localparam int unsigned ZERO_W          = 12;
    localparam logic [11:0] T1_ZERO_RUN     = 12'h0C0;
    localparam logic [11:0] E1_ZERO_RUN     = 12'h0FF;
    localparam logic [11:0] E1_ZERO_RUN_EXT = 12'h800;

    typedef struct packed {
        logic clock_loss_pin_enable;
        logic extended_carrier_loss_select;
        logic crc4_enable;
        logic e1_mode;
    } cfg_t;

    typedef struct packed {
        logic input_level_low;
        logic line_carrier_loss;
        logic current_limit_exceeded;
        logic output_open_circuit;
        logic line_transmit_clock_loss;
        logic yellow_alarm_condition;
        logic unframed_all_ones_condition;
        logic loss_of_sync_condition;
        logic spare_code_detected;
        logic loop_down_detected;
        logic loop_up_detected;
        logic v52_link_detected;
        logic remote_alarm_condition;
    } detect_t;

    typedef struct packed {
        logic timer_event;
        logic signaling_change_event;
        logic jitter_limit_trip_event;
        logic ais_customer_pattern_event;
        logic signaling_all_ones_event;
        logic signaling_all_zeros_event;
        logic transmit_multiframe_event;
        logic transmit_align_frame_event;
        logic receive_multiframe_event;
        logic receive_crc4_multiframe_event;
        logic receive_align_frame_event;
    } event_t;

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import framer_alarm_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, clk_run = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_loss_pin, irq;
    detect_t     det = '0;
    event_t      evt = '0;
    logic        rx_bit_strobe = 1'b0, receive_positive_input = 1'b0, receive_negative_input = 1'b0;
    logic        ts16_frame0_bit6 = 1'b0, transmit_clock_pin = 1'b0, receive_data_clock_input = 1'b0;
    int          num_errors = 0, checked = 0;

    // short tick keeps the internal multiframe timer cheap to simulate
    framer_alarm_event_interrupts #(.MF_TICK_CYCLES(50)) framer_alarm_event_interrupts_inst (.*);

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        transmit_clock_pin       <= clk_run ? ~transmit_clock_pin : transmit_clock_pin;
        receive_data_clock_input <= ~receive_data_clock_input;
    end
////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ready is sampled mid-cycle, where it is settled, and acted on at the next edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a, w, ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= idx << 2;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clk_sys);
            a = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            @(posedge clk_sys);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            ad |= a;
            wd |= w;
        end
        do @(negedge clk_sys); while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        // bready stays up: lowering it here would clash with the next call's raise
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] idx);
        s_axi_araddr <= idx << 2;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk_sys); while (!s_axi_arready);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_sys); while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        @(posedge clk_sys);
    endtask

    task automatic wait_irq(input logic [31:0] exp, input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
        check("irq", exp, irq);
        @(posedge clk_sys);
    endtask
////////////////////////////////////////////////////////////
    task automatic t_reset_map();
        for (int i = 0; i < 6; i++) begin
            rd(8'h18 + i[7:0]);
            check("reset value", 32'h0, rd_data);
        end
        rd(8'h3F);
        check("unmapped read", RESP_SLVERR, rd_resp);
        wr(8'h3F, 8'h5A);
        check("unmapped write", RESP_SLVERR, wr_resp);
    endtask

    task automatic t_yellow();
        wr(IDX_RX_ALARM_MK, 8'h08);
        det.yellow_alarm_condition <= 1'b1;
        wait_irq(1, 3);
        rd(IDX_RX_ALARM_ST);
        check("yellow status", 32'h08, rd_data);
        det.yellow_alarm_condition <= 1'b0;
        wait_irq(0, 4);
        rd(IDX_RX_ALARM_ST);
        check("yellow clear", 32'h88, rd_data);
    endtask

    task automatic t_events();
        wr(IDX_FRAME_MK, 8'h10);
        evt.receive_multiframe_event <= 1'b1;
        @(posedge clk_sys);
        evt.receive_multiframe_event <= 1'b0;
        wait_irq(0, 2);
        evt.transmit_multiframe_event <= 1'b1;
        @(posedge clk_sys);
        evt.transmit_multiframe_event <= 1'b0;
        wait_irq(1, 2);
        rd(IDX_FRAME_ST);
        check("frame status", 32'h14, rd_data);
        wait_irq(0, 0);
    endtask

    task automatic t_carrier();
        rx_bit_strobe <= 1'b1;
        repeat (191) @(posedge clk_sys);
        rx_bit_strobe <= 1'b0;
        rd(IDX_RX_ALARM_ST);
        check("191 zeros", 32'h0, rd_data & 32'h2);
        rx_bit_strobe <= 1'b1;
        @(posedge clk_sys);
        rx_bit_strobe <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(IDX_RX_ALARM_ST);
        check("192 zeros", 32'h2, rd_data & 32'h2);
        rx_bit_strobe <= 1'b1;
        receive_positive_input <= 1'b1;
        @(posedge clk_sys);
        rx_bit_strobe <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(IDX_RX_ALARM_ST);
        check("carrier clear", 32'h22, rd_data);
    endtask

    task automatic t_clock_loss();
        wr(IDX_CONFIG, 8'h08);
        wr(IDX_LOOP_CLK_MK, 8'h10);
        clk_run <= 1'b0;
        wait_irq(1, 270);
        check("loss pin", 32'h1, clock_loss_pin);
        rd(IDX_LOOP_CLK_ST);
        check("tx clock loss", 32'h10, rd_data);
        clk_run <= 1'b1;
        wait_irq(1, 5);
        check("loss pin off", 32'h0, clock_loss_pin);
    endtask

    task automatic t_e1();
        wr(IDX_CONFIG, 8'h01);
        wr(IDX_LINE_MASK, 8'h08);
        wr(IDX_RX_ALARM_MK, 8'h01);
        wr(IDX_LOOP_CLK_MK, 8'h04);
        det.line_carrier_loss <= 1'b1;
        det.loss_of_sync_condition <= 1'b1;
        det.v52_link_detected <= 1'b1;
        wait_irq(1, 3);
        rd(IDX_SUMMARY);
        check("summary", 32'h07, rd_data);
        rd(IDX_LINE_STATUS);
        check("line status", 32'h08, rd_data);
        rd(IDX_RX_ALARM_ST);
        check("sync lost", 32'h01, rd_data);
        // transmit clock loss from the last scenario is still latched
        rd(IDX_LOOP_CLK_ST);
        check("link status", 32'h14, rd_data);
        wait_irq(0, 0);
        det.line_carrier_loss <= 1'b0;
        det.loss_of_sync_condition <= 1'b0;
        det.v52_link_detected <= 1'b0;
        wait_irq(1, 3);
        rd(IDX_RX_ALARM_ST);
        check("sync achieved", 32'h11, rd_data);
        repeat (50) @(posedge clk_sys);
        rd(IDX_FRAME_ST);
        check("crc4 tick", 32'h2, rd_data & 32'h2);
    endtask
////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset_map();
        t_yellow();
        t_events();
        t_carrier();
        t_clock_loss();
        t_e1();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
endmodule // testbench
